/* src/pcd_defines.svh */
// Timing and level constants for the pulse-count LED dimmer
`ifndef PCD_DEFINES_SVH
`define PCD_DEFINES_SVH

// ----------------------------------------------------------------------
// Clock
// ----------------------------------------------------------------------
`define PCD_CLK_PERIOD_NS      40
`define PCD_NS_PER_US          1000

// ----------------------------------------------------------------------
// Enable line timing, times in microseconds
// ----------------------------------------------------------------------
`define PCD_DIM_LOW_MIN_US     100
`define PCD_DIM_LOW_MAX_US     300
`define PCD_DIM_HIGH_MIN_US    100
`define PCD_SHDN_DELAY_US      1000

// Least times round up, longest times round down
`define PCD_DIM_LOW_MIN_CYC  ((`PCD_DIM_LOW_MIN_US * `PCD_NS_PER_US + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS)
`define PCD_DIM_LOW_MAX_CYC  ((`PCD_DIM_LOW_MAX_US * `PCD_NS_PER_US) / `PCD_CLK_PERIOD_NS)
`define PCD_DIM_HIGH_MIN_CYC ((`PCD_DIM_HIGH_MIN_US * `PCD_NS_PER_US + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS)
`define PCD_SHDN_DELAY_CYC   ((`PCD_SHDN_DELAY_US * `PCD_NS_PER_US + `PCD_CLK_PERIOD_NS - 1) / `PCD_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Widths and levels
// ----------------------------------------------------------------------
`define PCD_CNT_W              15
`define PCD_LEVEL_W            4
`define PCD_CHANNELS           5
`define PCD_LEVEL_FULL         4'hf
`define PCD_SYNC_RESET         1'b1

`endif

/* src/pcd_pkg.sv */
// Types for the pulse-count LED dimmer
`default_nettype none
`include "pcd_defines.svh"

package pcd_pkg;

  // Brightness code: 15 is full, 0 is one sixteenth
  typedef logic [`PCD_LEVEL_W-1:0] pcd_level_t;

  // Low interval counter
  typedef logic [`PCD_CNT_W-1:0] pcd_count_t;

  // Channel enables
  typedef logic [`PCD_CHANNELS-1:0] pcd_chan_t;

  // Line state, Gray coded along on -> low -> off
  typedef enum logic [1:0]
  {
    PCD_ST_ON  = 2'b00,
    PCD_ST_LOW = 2'b01,
    PCD_ST_OFF = 2'b11
  } pcd_state_e;

endpackage

`default_nettype wire

/* src/pcd_enable_sync.sv */
// Two-stage synchroniser for the enable pin
`timescale 1ns/1ps
`default_nettype none
`include "pcd_defines.svh"

module pcd_enable_sync
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pinIn,
  output var  logic syncOut
);

  logic meta_q;

  // ----------------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------------

  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q  <= `PCD_SYNC_RESET;
      syncOut <= `PCD_SYNC_RESET;
    end
    else
    begin
      meta_q  <= pinIn;
      syncOut <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* src/pcd_dimmer.sv */
// Pulse-count brightness decoder for a five-channel LED current sink
`timescale 1ns/1ps
`default_nettype none
`include "pcd_defines.svh"

// Behaviour
// - After reset all LED channels run at full brightness.
// - Brightness stays at full until the first valid dimming pulse.
// - Each valid pulse lowers brightness one step; fifteen reach one sixteenth.
// - A pulse at the lowest level wraps brightness back to full.
// - Valid pulse is a low interval between least and longest dimming low time.
// - Enable low for 1 ms shuts the device down instead of stepping.
module pcd_dimmer
#(
  parameter logic [`PCD_CNT_W-1:0] DIM_LOW_MAX_CYC = `PCD_CNT_W'(`PCD_DIM_LOW_MAX_CYC),
  parameter logic [`PCD_CNT_W-1:0] SHDN_DELAY_CYC  = `PCD_CNT_W'(`PCD_SHDN_DELAY_CYC)
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              dimEnable,
  output var  pcd_pkg::pcd_level_t dimLevel,
  output var  pcd_pkg::pcd_chan_t  ledChannel,
  output var  logic              deviceActive,
  output var  logic              dimStep
);

  import pcd_pkg::*;

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------

  // Shortest low interval that counts as a dimming pulse
  localparam pcd_count_t LowMinCyc = `PCD_CNT_W'(`PCD_DIM_LOW_MIN_CYC);

  // Full brightness code
  localparam pcd_level_t LevelFull = `PCD_LEVEL_FULL;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------

  logic       enSync;
  logic       enPrev_q;
  logic       riseEdge;
  logic       validPulse;
  logic       shdnReached;
  pcd_count_t lowCnt_q;
  pcd_count_t lowCnt_d;
  pcd_state_e state_q;
  pcd_state_e state_d;
  pcd_level_t level_q;
  pcd_level_t level_d;
  logic       chanOn;

  // True when the line state means the device is shut down
  function automatic logic isShutDown(input pcd_state_e st);
    return (st == PCD_ST_OFF);
  endfunction

  // ----------------------------------------------------------------------
  // Enable pin synchronisation
  // ----------------------------------------------------------------------

  // Pin is asynchronous to the oscillator, so two flops come first
  pcd_enable_sync u_enable_sync
  (
    .clk     (clk),
    .rst     (rst),
    .pinIn   (dimEnable),
    .syncOut (enSync)
  );

  // Previous synchronised level for edge detection
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enPrev_q <= `PCD_SYNC_RESET;
    end
    else
    begin
      enPrev_q <= enSync;
    end
  end

  // Rising edge marks the end of a low interval
  assign riseEdge = enSync & ~enPrev_q;

  // ----------------------------------------------------------------------
  // Low interval measurement
  // ----------------------------------------------------------------------

  // Counts synchronised low cycles, saturating at the shutdown delay
  always_comb
  begin
    lowCnt_d = lowCnt_q;
    if (enSync)
    begin
      lowCnt_d = '0;
    end
    else if (lowCnt_q != SHDN_DELAY_CYC)
    begin
      lowCnt_d = lowCnt_q + `PCD_CNT_W'(1);
    end
  end

  // Low counter register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lowCnt_q <= '0;
    end
    else
    begin
      lowCnt_q <= lowCnt_d;
    end
  end

  // Low interval long enough to shut the device down
  assign shdnReached = ~enSync && (lowCnt_d == SHDN_DELAY_CYC);

  // A pulse counts only if its low length lies inside the window
  assign validPulse = riseEdge && (state_q == PCD_ST_LOW)
                      && (lowCnt_q >= LowMinCyc)
                      && (lowCnt_q <= DIM_LOW_MAX_CYC);

  // ----------------------------------------------------------------------
  // Line state machine
  // ----------------------------------------------------------------------

  // Tracks running, measuring a low, and shut down
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PCD_ST_ON:
      begin
        if (!enSync)
        begin
          state_d = PCD_ST_LOW;
        end
      end
      PCD_ST_LOW:
      begin
        if (enSync)
        begin
          state_d = PCD_ST_ON;
        end
        else if (shdnReached)
        begin
          state_d = PCD_ST_OFF;
        end
      end
      PCD_ST_OFF:
      begin
        if (enSync)
        begin
          state_d = PCD_ST_ON;
        end
      end
      default:
      begin
        state_d = PCD_ST_ON;
      end
    endcase
  end

  // State register, running after reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= PCD_ST_ON;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Brightness level
  // ----------------------------------------------------------------------

  // Steps down per pulse, wraps from lowest to full, full on shutdown
  always_comb
  begin
    level_d = level_q;
    if (isShutDown(state_d))
    begin
      level_d = LevelFull;
    end
    else if (validPulse)
    begin
      level_d = level_q - `PCD_LEVEL_W'(1);
    end
  end

  // Level register, full after reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      level_q <= LevelFull;
    end
    else
    begin
      level_q <= level_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // Channels stay lit through dimming lows, dark only in shutdown
  assign chanOn = ~isShutDown(state_d);

  // One enable flop per channel
  generate
    for (genvar ch = 0; ch < `PCD_CHANNELS; ch++)
    begin : g_chan
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          ledChannel[ch] <= 1'b1;
        end
        else
        begin
          ledChannel[ch] <= chanOn;
        end
      end
    end
  endgenerate

  // Registered level, activity and step strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dimLevel     <= LevelFull;
      deviceActive <= 1'b1;
      dimStep      <= 1'b0;
    end
    else
    begin
      dimLevel     <= level_d;
      deviceActive <= chanOn;
      dimStep      <= validPulse;
    end
  end

endmodule

`default_nettype wire

/* verification/pcd_host_model.sv */
// Host that pulses the enable line of the dimmer
`timescale 1ns/1ps
`default_nettype none

module pcd_host_model
(
  input  wire logic clk,
  output var  logic dimEnable
);
  // Line idles high while the host is quiet
  initial dimEnable = 1'b1;

  // Low for loCyc sampled edges, then high for hiCyc edges
  task automatic lowPulse(input int loCyc, input int hiCyc);
    @(posedge clk) dimEnable <= 1'b0;
    repeat (loCyc - 1) @(posedge clk);
    @(posedge clk) dimEnable <= 1'b1;
    repeat (hiCyc) @(posedge clk);
  endtask
endmodule

`default_nettype wire

/* verification/pcd_dimmer_properties.sv */
// Port checks for the pulse-count dimmer
`timescale 1ns/1ps
`default_nettype none
`include "pcd_defines.svh"

module pcd_dimmer_props
#(
  parameter logic [`PCD_CNT_W-1:0] DIM_LOW_MAX_CYC = 15'h1d4c,
  parameter logic [`PCD_CNT_W-1:0] SHDN_DELAY_CYC  = 15'h61a8
)
(
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                dimEnable,
  input wire pcd_pkg::pcd_level_t dimLevel,
  input wire pcd_pkg::pcd_chan_t  ledChannel,
  input wire logic                deviceActive,
  input wire logic                dimStep
);
  import pcd_pkg::*;
  logic [15:0] lowRun_q;
  logic [15:0] lastLow_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Length of the current low run on the pin
  always_ff @(posedge clk)
    if (rst || dimEnable)
      lowRun_q <= 16'h0;
    else
      lowRun_q <= lowRun_q + 16'h1;

  // Length of the last finished low run
  always_ff @(posedge clk)
    if (rst)
      lastLow_q <= 16'h0;
    else if (dimEnable && lowRun_q != 16'h0)
      lastLow_q <= lowRun_q;

  property p_reset; $past(rst) |-> dimLevel == 4'hf && deviceActive; endproperty
  a_reset: assert property (p_reset) else $error("level not full after reset");
  property p_lit; deviceActive |-> ledChannel == 5'h1f; endproperty
  a_lit: assert property (p_lit) else $error("channels not at full drive");
  property p_hold; !dimStep && deviceActive |-> $stable(dimLevel); endproperty
  a_hold: assert property (p_hold) else $error("level moved without a step");
  property p_step; dimStep && $past(dimLevel) != 4'h0 |-> dimLevel == $past(dimLevel) - 4'h1; endproperty
  a_step: assert property (p_step) else $error("step did not lower level by one");
  property p_wrap; dimStep && $past(dimLevel) == 4'h0 |-> dimLevel == 4'hf; endproperty
  a_wrap: assert property (p_wrap) else $error("lowest level did not wrap");
  property p_len;
    dimStep |-> $past(dimEnable, 2) && lastLow_q >= 16'(`PCD_DIM_LOW_MIN_CYC) && lastLow_q <= 16'(DIM_LOW_MAX_CYC);
  endproperty
  a_len: assert property (p_len) else $error("step after out-of-range low");
  property p_once; dimStep |=> !dimStep [*3]; endproperty
  a_once: assert property (p_once) else $error("step pulse too long");
  property p_shdn;
    lowRun_q == 16'(SHDN_DELAY_CYC) + 16'h5 |-> !deviceActive && ledChannel == 5'h0 && dimLevel == 4'hf;
  endproperty
  a_shdn: assert property (p_shdn) else $error("no shutdown after long low");
  property p_quiet; !deviceActive |-> !dimStep; endproperty
  a_quiet: assert property (p_quiet) else $error("step while shut down");

  c_low: cover property (dimStep && dimLevel == 4'h0);
  c_wrap: cover property (dimStep && dimLevel == 4'hf);
  c_off: cover property ($fell(deviceActive));
endmodule

bind pcd_dimmer pcd_dimmer_props #(.DIM_LOW_MAX_CYC(DIM_LOW_MAX_CYC), .SHDN_DELAY_CYC(SHDN_DELAY_CYC)) u_props
  (.clk(clk), .rst(rst), .dimEnable(dimEnable), .dimLevel(dimLevel), .ledChannel(ledChannel),
   .deviceActive(deviceActive), .dimStep(dimStep));

`default_nettype wire

/* verification/test_pulse_count_led_dimmer.sv */
// Self-checking bench for the pulse-count dimmer
`timescale 1ns/1ps
`default_nettype none
`include "pcd_defines.svh"

module test_pulse_count_led_dimmer;
  import pcd_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       dimEnable;
  pcd_level_t dimLevel;
  pcd_chan_t  ledChannel;
  logic       deviceActive;
  logic       dimStep;
  int         errors = 0;
  int         n_compared = 0;
  int         nSteps = 0;
  int         expSteps = 0;
  int         expLevel = 15;
  int         seed = 96;
  int         expQ[$];

  // Shortened limits for simulation; the least low and high times keep their real values
  localparam int LowMin    = `PCD_DIM_LOW_MIN_CYC;
  localparam int HighCyc   = `PCD_DIM_HIGH_MIN_CYC;
  localparam int SimLowMax = 3000;
  localparam int SimShdn   = 3500;

  // 25 MHz clock
  always #20 clk = ~clk;

  pcd_dimmer #(.DIM_LOW_MAX_CYC(15'(SimLowMax)), .SHDN_DELAY_CYC(15'(SimShdn))) u_dut
    (.clk(clk), .rst(rst), .dimEnable(dimEnable), .dimLevel(dimLevel), .ledChannel(ledChannel),
     .deviceActive(deviceActive), .dimStep(dimStep));
  pcd_host_model u_host (.clk(clk), .dimEnable(dimEnable));

  // Count step pulses and check each against the level the model queued
  always @(posedge clk)
    if (dimStep === 1'b1)
    begin
      nSteps <= nSteps + 1;
      chkSteps("queuedSteps", 1, expQ.size());
      if (expQ.size() > 0)
        chkLevel("stepLevel", expQ.pop_front(), dimLevel);
    end

  // Shared bookkeeping for every compare
  task automatic tally(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Brightness code against the model
  task automatic chkLevel(input string nm, input int exp, input pcd_level_t got);
    tally(nm, 16'(exp), 16'(got));
  endtask

  // Channel enables against the model
  task automatic chkChan(input string nm, input int exp, input pcd_chan_t got);
    tally(nm, 16'(exp), 16'(got));
  endtask

  // Activity flag against the model
  task automatic chkActive(input string nm, input int exp, input logic got);
    tally(nm, 16'(exp), 16'(got));
  endtask

  // Step counts against the model
  task automatic chkSteps(input string nm, input int exp, input int got);
    tally(nm, 16'(exp), 16'(got));
  endtask

  // One low pulse; the model predicts before the host drives it
  task automatic pulse(input int lo);
    if (lo >= LowMin && lo <= SimLowMax)
    begin
      expLevel = (expLevel + 15) % 16;
      expSteps++;
      expQ.push_back(expLevel);
    end
    u_host.lowPulse(lo, HighCyc);
    chkLevel("dimLevel", expLevel, dimLevel);
    chkSteps("steps", expSteps, nSteps);
  endtask

  task automatic end_of_test;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (120000) @(posedge clk);
    errors++;
    end_of_test();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (100) @(posedge clk);
    chkLevel("dimLevel", 4'hf, dimLevel);
    chkChan("ledChannel", 5'h1f, ledChannel);
    chkActive("deviceActive", 1'h1, deviceActive);
    pulse(100);
    pulse(SimLowMax + 200);
    pulse(LowMin);
    u_host.lowPulse(SimShdn + 100, 0);
    chkActive("deviceActive", 1'h0, deviceActive);
    chkChan("ledChannel", 5'h0, ledChannel);
    chkLevel("dimLevel", 4'hf, dimLevel);
    repeat (HighCyc) @(posedge clk);
    expLevel = 15;
    chkLevel("dimLevel", 4'hf, dimLevel);
    chkActive("deviceActive", 1'h1, deviceActive);
    chkChan("ledChannel", 5'h1f, ledChannel);
    pulse(SimLowMax);
    for (int i = 0; i < 15; i++)
      pulse(LowMin + $unsigned($random(seed)) % (SimLowMax - LowMin + 1));
    end_of_test();
  end
endmodule

`default_nettype wire
